//--- hw/cslr_pkg.sv
// package for the communication switch configuration loader
`default_nettype none

package cslr_pkg;

    // ==========================================================
    // register map (byte offsets)
    localparam logic [4:0] OFF_STATUS  = 5'h00;
    localparam logic [4:0] OFF_CONFIG  = 5'h04;
    localparam logic [4:0] OFF_LIVE    = 5'h08;
    localparam logic [4:0] OFF_CONTROL = 5'h0C;
    localparam logic [4:0] OFF_BYTES   = 5'h10;

    // status bit positions
    localparam int ST_LOADED_BIT = 0;
    localparam int ST_ERROR_BIT  = 1;
    localparam int ST_LENBAD_BIT = 2;
    localparam int ST_ADRBAD_BIT = 3;
    localparam int ST_ENABLE_BIT = 4;
    // config field positions
    localparam int CF_ADDR_LSB   = 0;
    localparam int CF_LEN_LSB    = 8;
    localparam int CF_OPT_LSB    = 12;
    // control reset value
    localparam logic CTRL_ALLOW_RST = 1'h1;

    // ==========================================================
    // frame length codes {pin2, pin1} and their byte counts
    localparam logic [1:0] LEN_16   = 2'h0;
    localparam logic [1:0] LEN_32   = 2'h1;
    localparam logic [1:0] LEN_48   = 2'h2;
    localparam logic [1:0] LEN_RSVD = 2'h3;
    localparam logic [5:0] BYTES_16 = 6'h10;
    localparam logic [5:0] BYTES_32 = 6'h20;
    localparam logic [5:0] BYTES_48 = 6'h30;
    localparam logic [5:0] BYTES_NONE = 6'h00;

    // usable station address window
    localparam logic [7:0] ADDR_MIN = 8'h03;
    localparam logic [7:0] ADDR_MAX = 8'hEF;

    // settle count after reset; the switches are captured 10 cycles after reset ends
    localparam logic [3:0] SETTLE_CYCLES = 4'h8;

    // ==========================================================
    typedef struct packed {
        logic [3:0] opt;
        logic [3:0] hi;
        logic [3:0] lo;
    } cslr_sw_t;

    typedef struct packed {
        logic [3:0] opt;
        logic [1:0] len;
        logic [7:0] addr;
        logic       len_bad;
        logic       addr_bad;
    } cslr_cfg_t;

    typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} cslr_state_t;

    function automatic logic [5:0] len_bytes(input logic [1:0] code);
        unique case (code)
            LEN_16:  len_bytes = BYTES_16;
            LEN_32:  len_bytes = BYTES_32;
            LEN_48:  len_bytes = BYTES_48;
            default: len_bytes = BYTES_NONE;
        endcase
    endfunction : len_bytes

    function automatic logic addr_usable(input logic [7:0] a);
        addr_usable = (a >= ADDR_MIN) && (a <= ADDR_MAX);
    endfunction : addr_usable

endpackage : cslr_pkg

`default_nettype wire

//--- hw/cslr_sync.sv
// two-stage synchroniser for the switch pins
`default_nettype none

module cslr_sync
#(
    parameter int W = 12
)
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // pins and synchronised copy
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end

endmodule : cslr_sync

`default_nettype wire

//--- hw/cslr_decode.sv
// decodes raw switch settings into frame length and station address
`default_nettype none

module cslr_decode
(
    // raw switch settings
    input  wire cslr_pkg::cslr_sw_t  sw,
    // decoded configuration
    output cslr_pkg::cslr_cfg_t      cfg
);

    // {pin2, pin1}: pin1 on gives 32, pin2 on gives 48
    wire logic [1:0] len_code = {sw.opt[1], sw.opt[0]};     // see RQ1
    // high rotary is the upper digit
    wire logic [7:0] addr     = {sw.hi, sw.lo};             // see RQ5

    assign cfg.opt      = sw.opt;
    assign cfg.len      = len_code;
    assign cfg.addr     = addr;
    assign cfg.len_bad  = (len_code == cslr_pkg::LEN_RSVD); // see RQ1
    assign cfg.addr_bad = !cslr_pkg::addr_usable(addr);     // see RQ6

endmodule : cslr_decode

`default_nettype wire

//--- hw/cslr_loader.sv
// configuration loader top: captures switches once, reports over avalon
// Functional notes
// RQ1 - option pins 1,2: off/off 16, pin1 32, pin2 48, both reserved
// RQ2 - master using standard profile needs frame length 32 or 48
// RQ3 - master using legacy profile needs frame length 16 or 32
// RQ4 - switches sampled only at power-up; later changes ignored
// RQ5 - address is high rotary digit then low rotary digit
// RQ6 - addresses 00-02 and F0-FF are disabled; 03-EF usable
// RQ7 - option pins 3 and 4 are reserved, left as delivered
// RQ8 - reserved length or disabled address flags error, comm stays off
//
// The Avalon-MM register port and the address map were left to the implementer.
`default_nettype none

module cslr_loader
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // board switches
    input  wire logic [3:0]  comm_option_switch,
    input  wire logic [3:0]  address_high_rotary,
    input  wire logic [3:0]  address_low_rotary,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // to the communication stack
    output logic             config_valid,
    output logic             config_error,
    output logic             comm_enable,
    output logic [1:0]       frame_len_code,
    output logic [5:0]       frame_bytes,
    output logic [7:0]       station_addr
);

    // ==========================================================
    // synchronised switches and their decode
    cslr_pkg::cslr_sw_t  sw_raw;
    cslr_pkg::cslr_sw_t  sw_s;
    cslr_pkg::cslr_cfg_t cfg_live;

    assign sw_raw.opt = comm_option_switch;
    assign sw_raw.hi  = address_high_rotary;
    assign sw_raw.lo  = address_low_rotary;

    cslr_sync #(.W(12)) u_sync
    (
        .clock    (clock),
        .resetn   (resetn),
        .pin_in   (sw_raw),
        .sync_out (sw_s)
    );

    cslr_decode u_decode
    (
        .sw  (sw_s),
        .cfg (cfg_live)
    );

    // ==========================================================
    // power-up capture sequence
    cslr_pkg::cslr_state_t state_q;
    cslr_pkg::cslr_state_t state_d;
    logic [3:0]            cnt_q;
    logic [3:0]            cnt_d;
    cslr_pkg::cslr_cfg_t   cfg_q;
    logic                  loaded_q;
    logic                  error_q;
    logic                  enable_q;
    logic [5:0]            bytes_q;
    logic                  allow_q;

    wire logic settle_done = (cnt_q == cslr_pkg::SETTLE_CYCLES);
    wire logic do_load     = (state_q == cslr_pkg::ST_LOAD);
    wire logic cfg_error   = cfg_q.len_bad || cfg_q.addr_bad;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            cslr_pkg::ST_SETTLE:
            begin
                cnt_d = cnt_q + 4'h1;
                if (settle_done)
                    state_d = cslr_pkg::ST_LOAD;
            end
            cslr_pkg::ST_LOAD:
                state_d = cslr_pkg::ST_RUN;
            // only a reset leaves the run state
            cslr_pkg::ST_RUN:
                state_d = cslr_pkg::ST_RUN;                 // see RQ4
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state_q <= cslr_pkg::ST_SETTLE;
            cnt_q   <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // capture once; nothing reloads until the next reset
    always_ff @(posedge clock)
    begin
        if (!resetn)
            cfg_q <= '0;
        else if (do_load)
            cfg_q <= cfg_live;                              // see RQ4
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            loaded_q <= 1'b0;
            bytes_q  <= cslr_pkg::BYTES_NONE;
        end
        else if (do_load)
        begin
            loaded_q <= 1'b1;
            bytes_q  <= cslr_pkg::len_bytes(cfg_live.len);  // see RQ1
        end
    end

    // error follows the captured setting; enable also needs the control allow bit
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            error_q  <= 1'b0;
            enable_q <= 1'b0;
        end
        else
        begin
            error_q  <= loaded_q && cfg_error;              // see RQ8
            enable_q <= loaded_q && !cfg_error && allow_q;  // see RQ8
        end
    end

    // ==========================================================
    // avalon slave: one wait cycle, then answer
    logic        wait_q;
    logic [31:0] rdata_q;

    wire logic        req     = avs_read || avs_write;
    wire logic        accept  = req && wait_q;
    wire logic [4:0]  word    = {avs_address[4:2], 2'b00};
    wire logic        wr_done = avs_write && !wait_q;
    wire logic        wr_ctrl = wr_done && (word == cslr_pkg::OFF_CONTROL)
                                && avs_byteenable[0];

    wire logic [31:0] st_word = {27'h0, enable_q, cfg_q.addr_bad,
                                 cfg_q.len_bad, error_q, loaded_q};
    wire logic [31:0] cf_word = {16'h0, cfg_q.opt, 2'b00, cfg_q.len,
                                 cfg_q.addr};
    wire logic [31:0] lv_word = {20'h0, sw_s};
    wire logic [31:0] ct_word = {31'h0, allow_q};
    wire logic [31:0] by_word = {26'h0, bytes_q};

    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (word)
            cslr_pkg::OFF_STATUS:  rd_mux = st_word;
            cslr_pkg::OFF_CONFIG:  rd_mux = cf_word;
            cslr_pkg::OFF_LIVE:    rd_mux = lv_word;
            cslr_pkg::OFF_CONTROL: rd_mux = ct_word;
            cslr_pkg::OFF_BYTES:   rd_mux = by_word;
            default:               rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            wait_q  <= !accept;
            rdata_q <= (accept && avs_read) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            allow_q <= cslr_pkg::CTRL_ALLOW_RST;
        else if (wr_ctrl)
            allow_q <= avs_writedata[0];
    end

    // ==========================================================
    // outputs
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign config_valid    = loaded_q;
    assign config_error    = error_q;
    assign comm_enable     = enable_q;
    assign frame_len_code  = cfg_q.len;
    assign frame_bytes     = bytes_q;
    assign station_addr    = cfg_q.addr;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_cfg_frozen: assert property (                  // see RQ4
        loaded_q && $past(loaded_q) |-> $stable(cfg_q) && $stable(bytes_q))
        else $error("captured configuration changed after load");

    a_load_bounded: assert property (                // see RQ4
        $rose(resetn) |-> ##[9:12] loaded_q)
        else $error("configuration not captured after reset");

    a_len_bytes: assert property (                   // see RQ1
        do_load |=> (bytes_q == ($past(sw_s.opt[1:0]) == 2'h0 ? 6'h10 :
                                 $past(sw_s.opt[1:0]) == 2'h1 ? 6'h20 :
                                 $past(sw_s.opt[1:0]) == 2'h2 ? 6'h30 : 6'h00)))
        else $error("frame length decoded wrongly");

    a_addr_digits: assert property (                 // see RQ5
        do_load |=> station_addr == {$past(address_high_rotary, 3),
                                     $past(address_low_rotary, 3)}
                    || !$stable(sw_s))
        else $error("station address digits misordered");

    a_addr_window: assert property (                 // see RQ6
        loaded_q |-> cfg_q.addr_bad ==
                     (cfg_q.addr < 8'h03 || cfg_q.addr > 8'hEF))
        else $error("disabled address window wrong");

    a_error_flag: assert property (                  // see RQ8
        loaded_q ##1 loaded_q |-> config_error ==
                     (cfg_q.len == 2'h3 || cfg_q.addr_bad))
        else $error("configuration error flag wrong");

    a_error_no_comm: assert property (               // see RQ8
        config_error |-> !comm_enable)
        else $error("communication enabled despite error");

    a_enable_rule: assert property (                 // see RQ8
        loaded_q ##1 loaded_q |-> comm_enable ==
                     (!cfg_q.len_bad && !cfg_q.addr_bad && $past(allow_q)))
        else $error("communication enable disagrees with configuration");

    a_error_stays: assert property (                 // see RQ8
        config_error |=> config_error)
        else $error("configuration error cleared without reset");

    a_quiet_before_load: assert property (           // see RQ4
        !loaded_q |-> !comm_enable && !config_error && frame_bytes == 6'h00
                      && station_addr == 8'h00)
        else $error("configuration outputs active before load");

    a_run_sticky: assert property (                  // see RQ4
        state_q == cslr_pkg::ST_RUN |=> state_q == cslr_pkg::ST_RUN)
        else $error("run state left without reset");

    a_load_once: assert property (                   // see RQ4
        do_load |=> !do_load && loaded_q)
        else $error("switch capture repeated or lost");

    a_len_known: assert property (                   // see RQ1
        loaded_q |-> (frame_bytes == 6'h00) == cfg_q.len_bad)
        else $error("reserved length not reported as zero bytes");

    a_bus_answer: assert property (
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    // ==========================================================
    // bus side checks
    a_bus_idle: assert property (
        !req |=> avs_waitrequest)
        else $error("bus answered without a request");

    a_idle_readdata: assert property (
        avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("read data not zero outside an answer");

    a_ctrl_refused: assert property (
        wr_done && !avs_byteenable[0] |=> $stable(allow_q))
        else $error("control changed by write without lane zero");

    a_ctrl_write: assert property (
        wr_ctrl |=> allow_q == $past(avs_writedata[0]))
        else $error("control write not applied");

    c_good_load:  cover property ($rose(comm_enable));
    c_len_rsvd:   cover property (loaded_q && cfg_q.len_bad);
    c_addr_off:   cover property (loaded_q && cfg_q.addr_bad);
    c_ctrl_write: cover property (wr_ctrl && !avs_writedata[0]);
    c_ctrl_refused: cover property (wr_done && !avs_byteenable[0]);

endmodule : cslr_loader

`default_nettype wire

//--- tb/cslr_switch_bank.sv
// model of the board switch bank that an installer sets
`default_nettype none

module cslr_switch_bank
(
    // settings chosen by the installer
    input  wire logic [1:0] set_len,
    input  wire logic [7:0] set_addr,
    // switch pins
    output logic      [3:0] comm_option_switch,
    output logic      [3:0] address_high_rotary,
    output logic      [3:0] address_low_rotary
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // pins 3 and 4 stay in their delivered off state
    assign comm_option_switch  = {2'h0, set_len};
    assign address_high_rotary = set_addr[7:4];
    assign address_low_rotary  = set_addr[3:0];

endmodule : cslr_switch_bank

`default_nettype wire

//--- tb/cslr_loader_test.sv
// self-checking bench for the switch configuration loader
`default_nettype none

module cslr_loader_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  set_len = 2'h2;
    logic [7:0]  set_addr = 8'h03;
    logic [3:0]  opt_w;
    logic [3:0]  hi_w;
    logic [3:0]  lo_w;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic [31:0] rd_q;
    logic        avs_waitrequest;
    logic        config_valid;
    logic        config_error;
    logic        comm_enable;
    logic [1:0]  frame_len_code;
    logic [5:0]  frame_bytes;
    logic [7:0]  station_addr;
    int          errors = 0;
    int          checks = 0;
    // corner settings {length code, address}, factory state first
    logic [9:0]  cases [8] = '{10'h203, 10'h002, 10'h1EF, 10'h380,
                               10'h2F0, 10'h100, 10'h0FF, 10'h303};

    always #25 clock = ~clock;

    cslr_switch_bank i_bank (.set_len(set_len), .set_addr(set_addr),
        .comm_option_switch(opt_w), .address_high_rotary(hi_w),
        .address_low_rotary(lo_w));

    cslr_loader i_dut (.clock(clock), .resetn(resetn), .comm_option_switch(opt_w),
        .address_high_rotary(hi_w), .address_low_rotary(lo_w),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .config_valid(config_valid), .config_error(config_error),
        .comm_enable(comm_enable), .frame_len_code(frame_len_code),
        .frame_bytes(frame_bytes), .station_addr(station_addr));

    // ==========================================================
    // expectations
    function automatic logic [5:0] exp_bytes(input logic [1:0] c);
        exp_bytes = (c == 2'h3) ? 6'h00 : 6'h10 + 6'h10 * c;
    endfunction : exp_bytes

    function automatic logic adr_bad(input logic [7:0] a);
        adr_bad = (a < 8'h03) || (a > 8'hEF);
    endfunction : adr_bad

    // master side: frame lengths each command profile accepts
    function automatic logic fits_std(input logic [5:0] b);
        fits_std = (b == 6'h20) || (b == 6'h30);
    endfunction : fits_std

    function automatic logic fits_legacy(input logic [5:0] b);
        fits_legacy = (b == 6'h10) || (b == 6'h20);
    endfunction : fits_legacy

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // ==========================================================
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        // only the watchdog ends a wait that never gets its answer
        do
        begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // power cycle with new switch settings
    task automatic power_up(input logic [1:0] c, input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clock);
        resetn <= 1'b0;
        set_len <= c;
        set_addr <= a;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        while (config_valid !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        repeat (2) @(posedge clock);
    endtask : power_up

    // ==========================================================
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end

    initial
    begin
        logic [1:0] c;
        logic [7:0] a;
        logic       e;
        void'($urandom(32'h9E44A57C));
        for (int i = 0; i < 16; i++)
        begin
            c = (i < 8) ? cases[i][9:8] : 2'($urandom % 4);
            a = (i < 8) ? cases[i][7:0] : 8'($urandom);
            e = (c == 2'h3) || adr_bad(a);
            power_up(c, a);
            check("valid", config_valid, 1'b1);
            check("len code", frame_len_code, c);
            check("bytes", frame_bytes, exp_bytes(c));
            check("address", station_addr, a);
            check("error", config_error, e);
            check("enable", comm_enable, !e);
            check("std profile", fits_std(frame_bytes), c == 2'h1 || c == 2'h2);
            check("legacy profile", fits_legacy(frame_bytes), c == 2'h0 || c == 2'h1);
            bus(1'b0, 5'h00, 32'h0, 4'hF);
            check("status", rd_q, {27'h0, ~e, adr_bad(a), c == 2'h3, e, 1'b1});
            bus(1'b0, 5'h04, 32'h0, 4'hF);
            check("config", rd_q, {16'h0, 2'h0, c, 2'h0, c, a});
            // running changes must reach only the live view
            set_len <= ~c;
            set_addr <= ~a;
            repeat (6) @(posedge clock);
            check("held address", station_addr, a);
            check("held len", frame_len_code, c);
            bus(1'b0, 5'h08, 32'h0, 4'hF);
            check("live", rd_q, {20'h0, 2'h0, ~c, ~a});
            if (!e)
            begin
                bus(1'b1, 5'h0C, 32'h0, 4'h0);
                repeat (3) @(posedge clock);
                check("enable kept", comm_enable, 1'b1);
                bus(1'b1, 5'h0C, 32'h0, 4'h1);
                repeat (3) @(posedge clock);
                check("enable off", comm_enable, 1'b0);
            end
            $display("test %0d done", i);
        end
        bus(1'b1, 5'h00, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 5'h14, 32'h0, 4'hF);
        check("unmapped", rd_q, 32'h0);
        bus(1'b0, 5'h10, 32'h0, 4'hF);
        check("bytes reg", rd_q, {26'h0, exp_bytes(c)});
        $display("test extra done");
        test_done();
    end

endmodule : cslr_loader_test

`default_nettype wire
